// ==== isr_pkg.sv ====
/*
 * Shared constants and types of the instrument status reporting block:
 * summary byte layout, event bit layout, reset values, command codes.
 * Assumes one system clock and a parser that issues one command at a time.
 */
`default_nettype none

package isr_pkg;

   // Widths
   localparam int STB_W = 8;
   localparam int STD_W = 8;
   localparam int QUESTIONABLE_SUMMARY_W = 16;
   localparam int DATA_W = 16;
   localparam int ERR_W = 16;
   localparam int ERR_DEPTH_DEF = 20;

   // Summary byte bit positions
   localparam int STB_QUESTIONABLE_SUMMARY_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_RQS_BIT = 6;
   localparam logic [STB_W-1:0] STB_RQS_MASK = 8'h40;

   // Standard event bits; bits 1 and 6 always read zero
   localparam int STD_OPC_BIT = 0;
   localparam int STD_PON_BIT = 7;
   localparam logic [STD_W-1:0] STD_EVT_MASK = 8'hBD;

   // Questionable event bits
   localparam int QB_VOLT = 0;
   localparam int QB_CURR = 1;
   localparam int QB_FAN = 4;
   localparam int QB_OVP = 9;
   localparam logic [QUESTIONABLE_SUMMARY_W-1:0] QUESTIONABLE_SUMMARY_EVT_MASK = 16'h0213;

   // Regulation and fault pins
   localparam int PIN_N = 4;
   localparam int PIN_CC = 0;
   localparam int PIN_CV = 1;
   localparam int PIN_FAN = 2;
   localparam int PIN_OVP = 3;

   // Reset values
   localparam logic [STD_W-1:0] STD_EV_RST = 8'h00;
   localparam logic [QUESTIONABLE_SUMMARY_W-1:0] QUESTIONABLE_SUMMARY_EV_RST = 16'h0000;
   localparam logic [STD_W-1:0] ESE_RST = 8'h00;
   localparam logic [STB_W-1:0] SRE_RST = 8'h00;
   localparam logic [QUESTIONABLE_SUMMARY_W-1:0] QEN_RST = 16'h0000;
   localparam logic PSC_RST = 1'b1;

   // Fixed replies
   localparam logic [DATA_W-1:0] ERR_NONE = 16'h0000;
   localparam logic [DATA_W-1:0] OPC_Q_REPLY = 16'h0001;

   typedef enum logic [3:0] {
      CMD_CLS = 4'h0,
      CMD_ESE_WR = 4'h1,
      CMD_ESE_RD = 4'h2,
      CMD_ESR_RD = 4'h3,
      CMD_OPC = 4'h4,
      CMD_OPC_Q = 4'h5,
      CMD_PSC_WR = 4'h6,
      CMD_PSC_RD = 4'h7,
      CMD_SRE_WR = 4'h8,
      CMD_SRE_RD = 4'h9,
      CMD_STB_RD = 4'hA,
      CMD_QEN_WR = 4'hB,
      CMD_QEN_RD = 4'hC,
      CMD_QEV_RD = 4'hD,
      CMD_QCOND_RD = 4'hE,
      CMD_ERR_RD = 4'hF
   } isr_cmd_t;

   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN = 2'b10
   } isr_state_t;

endpackage : isr_pkg

`default_nettype wire

// ==== isr_err_fifo.sv ====
/*
 * Error queue: first in, first out, oldest entry at the head.
 * Assumes the producer holds push_valid until push_ready; a pop on an
 * empty queue is ignored.
 */
`timescale 1ns/100ps
`default_nettype none

module isr_err_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 20
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Fill side
   input wire logic push_valid,
   input wire logic [W-1:0] push_data,
   output logic push_ready,
   // Drain side
   input wire logic pop,
   output logic [W-1:0] pop_data,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] rd_q;
   logic [AW-1:0] wr_q;
   logic [CW-1:0] cnt_q;
   logic push_ok;
   logic pop_ok;

   assign empty = (cnt_q == '0);
   assign push_ready = (cnt_q != CW'(DEPTH));
   assign push_ok = push_valid & push_ready;
   assign pop_ok = pop & ~empty;
   assign pop_data = mem_q[rd_q];

   always_ff @(posedge clock) begin
      if (push_ok) begin
         mem_q[wr_q] <= push_data;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push_ok) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         end
         if (pop_ok) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (push_ok && !pop_ok) begin
         cnt_q <= cnt_q + CW'(1);
      end else if (pop_ok && !push_ok) begin
         cnt_q <= cnt_q - CW'(1);
      end
   end

endmodule : isr_err_fifo

`default_nettype wire

// ==== isr_status.sv ====
/*
 * Status reporting of an instrument remote interface: standard and
 * questionable event groups, summary byte, service request, serial poll,
 * common status commands and the error queue.
 * Assumes a parser on the same clock issuing decoded commands in order,
 * an output buffer that reports pending and full levels, and a store
 * that keeps the power-on clear setting and the two masks over power-off.
 */
`timescale 1ns/100ps
`default_nettype none

module isr_status
   import isr_pkg::*;
#(
   parameter int ERR_DEPTH = ERR_DEPTH_DEF
) (
   // Clock and power-on reset
   input wire logic clock,
   input wire logic resetn,
   // Settings kept across power-off
   input wire logic psc_nv,
   input wire logic [STD_W-1:0] ese_nv,
   input wire logic [STB_W-1:0] sre_nv,
   output logic psc_save,
   output logic [STD_W-1:0] ese_save,
   output logic [STB_W-1:0] sre_save,
   // Decoded commands and their replies
   input wire logic cmd_valid,
   input wire isr_cmd_t cmd_code,
   input wire logic [DATA_W-1:0] cmd_data,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_data,
   // Output buffer state
   input wire logic outbuf_pending,
   input wire logic outbuf_full,
   // Event and error sources
   input wire logic [STD_W-1:0] std_event,
   input wire logic err_valid,
   input wire logic [ERR_W-1:0] err_code,
   output logic err_ready,
   output logic error_active,
   // Regulation and fault pins
   input wire logic [PIN_N-1:0] pin_in,
   // Serial poll and service request
   input wire logic poll_req,
   output logic poll_ack,
   output logic [STB_W-1:0] poll_byte,
   output logic srq
);

   isr_state_t state_q;
   logic booting;
   logic [PIN_N-1:0] pin_q;
   logic [STD_W-1:0] std_ev_q;
   logic [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_ev_q;
   logic [STD_W-1:0] ese_q;
   logic [STB_W-1:0] sre_q;
   logic [QUESTIONABLE_SUMMARY_W-1:0] qen_q;
   logic psc_q;
   logic rqs_q;
   logic req_prev_q;
   logic [STB_W-1:0] stb;
   logic req_now;
   logic rd_clr;
   logic take;
   logic do_cls;
   logic do_esr_rd;
   logic do_qev_rd;
   logic do_opc;
   logic [STD_W-1:0] std_set;
   logic [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_set;
   logic [1:0] cond;
   logic [DATA_W-1:0] rsp_d;
   logic rsp_v_d;
   logic rsp_valid_q;
   logic [DATA_W-1:0] rsp_data_q;
   logic poll_ack_q;
   logic [STB_W-1:0] poll_byte_q;
   logic fifo_empty;
   logic [ERR_W-1:0] fifo_data;
   logic fifo_pop;

   // Power-up sequence: one cycle to restore settings, then run
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_BOOT;
      end else begin
         case (state_q)
            ST_BOOT: state_q <= ST_RUN;
            ST_RUN: state_q <= ST_RUN;
            default: state_q <= ST_BOOT;
         endcase
      end
   end

   assign booting = (state_q == ST_BOOT);

   // Three-stage pin synchronisers; a level counts once stages 2 and 3 agree
   genvar g;
   generate
      for (g = 0; g < PIN_N; g++) begin : g_sync
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic f_q;
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               f_q <= 1'b0;
            end else begin
               s1_q <= pin_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  f_q <= s3_q;
               end
            end
         end
         assign pin_q[g] = f_q;
      end
   endgenerate

   // Command decode; stalled while the output buffer is full
   assign cmd_ready = ~booting & ~outbuf_full;
   assign take = cmd_valid & cmd_ready;
   assign do_cls = take & (cmd_code == CMD_CLS);
   assign do_esr_rd = take & (cmd_code == CMD_ESR_RD);
   assign do_qev_rd = take & (cmd_code == CMD_QEV_RD);
   assign do_opc = take & (cmd_code == CMD_OPC);

   // Unlatched condition: bit 0 constant current, bit 1 constant voltage
   assign cond = {pin_q[PIN_CV], pin_q[PIN_CC]};

   // New event bits this cycle
   always_comb begin
      std_set = std_event;
      std_set[STD_OPC_BIT] = do_opc;
      std_set[STD_PON_BIT] = booting;
      std_set = std_set & STD_EVT_MASK;
      questionable_summary_set = '0;
      questionable_summary_set[QB_VOLT] = pin_q[PIN_CC];
      questionable_summary_set[QB_CURR] = pin_q[PIN_CV];
      questionable_summary_set[QB_FAN] = pin_q[PIN_FAN];
      questionable_summary_set[QB_OVP] = pin_q[PIN_OVP];
      questionable_summary_set = questionable_summary_set & QUESTIONABLE_SUMMARY_EVT_MASK;
   end

   // Standard event register: sticky, a new event wins over the clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         std_ev_q <= STD_EV_RST;
      end else begin
         std_ev_q <= ((do_cls | do_esr_rd) ? '0 : std_ev_q) | std_set;
      end
   end

   // Questionable event register: sticky, read returns then clears
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         questionable_summary_ev_q <= QUESTIONABLE_SUMMARY_EV_RST;
      end else begin
         questionable_summary_ev_q <= ((do_cls | do_qev_rd) ? '0 : questionable_summary_ev_q) | questionable_summary_set;
      end
   end

   // Enable masks and power-on clear setting; clear status leaves them
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ese_q <= ESE_RST;
         sre_q <= SRE_RST;
         psc_q <= PSC_RST;
      end else if (booting) begin
         psc_q <= psc_nv;
         ese_q <= psc_nv ? ESE_RST : ese_nv;
         sre_q <= psc_nv ? SRE_RST : (sre_nv & ~STB_RQS_MASK);
      end else if (take) begin
         case (cmd_code)
            CMD_ESE_WR: ese_q <= cmd_data[STD_W-1:0];
            CMD_SRE_WR: sre_q <= cmd_data[STB_W-1:0] & ~STB_RQS_MASK;
            CMD_PSC_WR: psc_q <= cmd_data[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         qen_q <= QEN_RST;
      end else if (take && cmd_code == CMD_QEN_WR) begin
         qen_q <= cmd_data;
      end
   end

   // Summary byte, formed from live registers so clears show at once
   always_comb begin
      stb = '0;
      stb[STB_QUESTIONABLE_SUMMARY_BIT] = |(questionable_summary_ev_q & qen_q);
      stb[STB_MAV_BIT] = outbuf_pending;
      stb[STB_ESB_BIT] = |(std_ev_q & ese_q);
      stb[STB_RQS_BIT] = rqs_q;
   end

   assign req_now = |(stb & sre_q & ~STB_RQS_MASK);

   // Reading the register behind an enabled summary bit drops the request
   assign rd_clr = (do_esr_rd & stb[STB_ESB_BIT] & sre_q[STB_ESB_BIT])
                 | (do_qev_rd & stb[STB_QUESTIONABLE_SUMMARY_BIT] & sre_q[STB_QUESTIONABLE_SUMMARY_BIT]);

   // Request-service bit: set on a rising enabled summary, set wins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rqs_q <= 1'b0;
         req_prev_q <= 1'b0;
      end else begin
         req_prev_q <= req_now;
         if (req_now && !req_prev_q) begin
            rqs_q <= 1'b1;
         end else if (poll_req || do_cls || rd_clr) begin
            rqs_q <= 1'b0;
         end
      end
   end

   assign srq = rqs_q;

   // Serial poll answered outside the command stream
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         poll_ack_q <= 1'b0;
         poll_byte_q <= '0;
      end else begin
         poll_ack_q <= poll_req;
         if (poll_req) begin
            poll_byte_q <= stb;
         end
      end
   end

   // Error queue
   assign fifo_pop = take & (cmd_code == CMD_ERR_RD);

   isr_err_fifo #(
      .W(ERR_W),
      .DEPTH(ERR_DEPTH)
   ) u_err_fifo (
      .clock(clock),
      .resetn(resetn),
      .push_valid(err_valid),
      .push_data(err_code),
      .push_ready(err_ready),
      .pop(fifo_pop),
      .pop_data(fifo_data),
      .empty(fifo_empty)
   );

   assign error_active = ~fifo_empty;

   // Query replies, in command order
   always_comb begin
      rsp_d = '0;
      rsp_v_d = 1'b1;
      case (cmd_code)
         CMD_ESE_RD: rsp_d[STD_W-1:0] = ese_q;
         CMD_ESR_RD: rsp_d[STD_W-1:0] = std_ev_q;
         CMD_OPC_Q: rsp_d = OPC_Q_REPLY;
         CMD_PSC_RD: rsp_d[0] = psc_q;
         CMD_SRE_RD: rsp_d[STB_W-1:0] = sre_q;
         CMD_STB_RD: rsp_d[STB_W-1:0] = stb;
         CMD_QEN_RD: rsp_d = qen_q;
         CMD_QEV_RD: rsp_d = questionable_summary_ev_q;
         CMD_QCOND_RD: rsp_d[1:0] = cond;
         CMD_ERR_RD: rsp_d = fifo_empty ? ERR_NONE : fifo_data;
         default: rsp_v_d = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= '0;
      end else begin
         rsp_valid_q <= take & rsp_v_d;
         if (take && rsp_v_d) begin
            rsp_data_q <= rsp_d;
         end
      end
   end

   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_data_q;
   assign poll_ack = poll_ack_q;
   assign poll_byte = poll_byte_q;
   assign psc_save = psc_q;
   assign ese_save = ese_q;
   assign sre_save = sre_q;

endmodule : isr_status

`default_nettype wire

// ==== isr_status_chk.sv ====
/* Port checker of the status reporting block.
   Bound to every isr_status instance; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module isr_status_chk
   import isr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Commands and replies
   input wire logic cmd_valid,
   input wire isr_cmd_t cmd_code,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic [DATA_W-1:0] rsp_data,
   input wire logic [STD_W-1:0] ese_save,
   // Buffer and errors
   input wire logic outbuf_pending,
   input wire logic outbuf_full,
   input wire logic err_valid,
   input wire logic err_ready,
   input wire logic error_active,
   // Serial poll
   input wire logic poll_req,
   input wire logic poll_ack,
   input wire logic [STB_W-1:0] poll_byte,
   input wire logic srq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   logic take;
   assign take = cmd_valid && cmd_ready;

   AST_POLL_ACK: assert property (poll_req |=> poll_ack)
      else $error("poll not acknowledged");
   AST_POLL_RQS: assert property (poll_req |=> poll_byte[6] == $past(srq))
      else $error("poll byte request bit wrong");
   AST_POLL_ZERO: assert property (poll_req |=> !poll_byte[7] && poll_byte[2:0] == 3'h0)
      else $error("poll byte unused bits set");
   AST_MAV: assert property (poll_req |=> poll_byte[4] == $past(outbuf_pending))
      else $error("message bit wrong");
   AST_STALL: assert property (outbuf_full |-> !cmd_ready)
      else $error("command taken while buffer full");
   AST_STB_Q: assert property (take && cmd_code == CMD_STB_RD |=> rsp_valid && rsp_data[6] == $past(srq) && rsp_data[15:8] == 8'h00)
      else $error("status query reply wrong");
   AST_ESE_ZERO: assert property (take && cmd_code == CMD_ESE_WR && cmd_data[7:0] == 8'h00 |=> ese_save == 8'h00)
      else $error("enable mask not cleared");
   AST_ERR_SET: assert property (err_valid && err_ready |=> error_active)
      else $error("error indicator not set");
   cover property (poll_req && srq);
   cover property (!err_ready);
   cover property (take && cmd_code == CMD_ESR_RD);
endmodule : isr_status_chk
bind isr_status isr_status_chk i_chk (.clock, .resetn, .cmd_valid,
   .cmd_code, .cmd_data, .cmd_ready, .rsp_valid, .rsp_data, .ese_save,
   .outbuf_pending, .outbuf_full, .err_valid, .err_ready, .error_active,
   .poll_req, .poll_ack, .poll_byte, .srq);
`default_nettype wire

// ==== isr_poller.sv ====
/* Bus controller model issuing serial polls on request.
   Runs on the status block clock; the bench calls poll. */
`timescale 1ns/100ps
`default_nettype none
module isr_poller
   import isr_pkg::*;
(
   // Clock
   input wire logic clock,
   // Serial poll
   output logic poll_req,
   input wire logic poll_ack,
   input wire logic [STB_W-1:0] poll_byte
);
   initial poll_req = 1'b0;
   // Waits lag cycles, pulses one request, takes the byte at the ack
   task automatic poll(input int lag, output logic [STB_W-1:0] b,
      output logic ok);
      ok = 1'b0;
      b = '0;
      repeat (lag) @(posedge clock);
      poll_req <= 1'b1;
      @(posedge clock);
      poll_req <= 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clock);
         ok = poll_ack;
         b = poll_byte;
      end
   endtask : poll
endmodule : isr_poller
`default_nettype wire

// ==== instrument_status_reporting_tb.sv ====
/* Self-checking bench of the status reporting block.
   Needs isr_pkg, isr_poller and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module instrument_status_reporting_tb
   import isr_pkg::*;
;
   localparam int DEP = 4;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic psc_nv, cmd_valid, outbuf_pending, outbuf_full, err_valid;
   logic psc_save, cmd_ready, rsp_valid, err_ready, error_active;
   logic poll_req, poll_ack, srq, ok;
   logic [STD_W-1:0] ese_nv, ese_save, std_event, ev, m;
   logic [STB_W-1:0] sre_nv, sre_save, poll_byte, b;
   logic [DATA_W-1:0] cmd_data, rsp_data, r;
   logic [ERR_W-1:0] err_code;
   logic [ERR_W-1:0] ec [DEP];
   logic [PIN_N-1:0] pin_in;
   isr_cmd_t cmd_code;
   int n_fail = 0;
   int cmp_count = 0;

   always #4 clock = ~clock;

   isr_status #(.ERR_DEPTH(DEP)) i_dut (
      .clock, .resetn, .psc_nv, .ese_nv, .sre_nv, .psc_save, .ese_save,
      .sre_save, .cmd_valid, .cmd_code, .cmd_data, .cmd_ready, .rsp_valid,
      .rsp_data, .outbuf_pending, .outbuf_full, .std_event, .err_valid,
      .err_code, .err_ready, .error_active, .pin_in, .poll_req, .poll_ack,
      .poll_byte, .srq);
   isr_poller i_ctl (.clock, .poll_req, .poll_ack, .poll_byte);

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic is_q(input isr_cmd_t c);
      return !(c inside {CMD_CLS, CMD_ESE_WR, CMD_OPC, CMD_PSC_WR,
         CMD_SRE_WR, CMD_QEN_WR});
   endfunction : is_q

   // Offers one command, holds it until taken, then takes the reply
   task automatic cmd(input isr_cmd_t c, input logic [15:0] d = 16'h0000);
      int i;
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (cmd_ready !== 1'b1 && i < 20);
      if (cmd_ready !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      cmd_valid <= 1'b0;
      @(posedge clock);
      r = rsp_data;
      chk({15'h0000, rsp_valid}, {15'h0000, is_q(c)});
   endtask : cmd

   task automatic q(input isr_cmd_t c, input logic [15:0] e);
      cmd(c);
      chk(r, e);
   endtask : q

   task automatic boot(input logic p);
      psc_nv <= p;
      resetn <= 1'b0;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
   endtask : boot

   initial begin
      {psc_nv, cmd_valid, outbuf_pending, outbuf_full, err_valid} = '0;
      ese_nv = 8'h24;
      sre_nv = 8'h60;
      std_event = '0;
      cmd_code = CMD_CLS;
      cmd_data = '0;
      err_code = '0;
      pin_in = '0;
      void'($urandom(32'h5260));
      @(posedge clock);
      boot(1'b0);
      chk(16'(ese_save), 16'h0024);
      chk(16'(sre_save), 16'h0020);
      chk(16'(psc_save), 16'h0000);
      q(CMD_ESR_RD, 16'h0080);
      q(CMD_ESR_RD, 16'h0000);
      boot(1'b1);
      chk(16'(ese_save), 16'h0000);
      chk(16'(sre_save), 16'h0000);
      chk(16'(psc_save), 16'h0001);
      cmd(CMD_CLS);
      cmd(CMD_ESE_WR, 16'h0001);
      cmd(CMD_SRE_WR, 16'h0020);
      q(CMD_OPC_Q, OPC_Q_REPLY);
      cmd(CMD_OPC);
      repeat (2) @(posedge clock);
      chk(16'(srq), 16'h0001);
      q(CMD_STB_RD, 16'h0060);
      i_ctl.poll(1, b, ok);
      chk(16'(ok), 16'h0001);
      chk(16'(b), 16'h0060);
      @(posedge clock);
      chk(16'(srq), 16'h0000);
      q(CMD_STB_RD, 16'h0020);
      outbuf_pending <= 1'b1;
      q(CMD_STB_RD, 16'h0030);
      q(CMD_ESR_RD, 16'h0001);
      q(CMD_STB_RD, 16'h0010);
      outbuf_pending <= 1'b0;
      cmd(CMD_OPC);
      repeat (2) @(posedge clock);
      q(CMD_ESR_RD, 16'h0001);
      @(posedge clock);
      chk(16'(srq), 16'h0000);
      q(CMD_STB_RD, 16'h0000);
      cmd(CMD_SRE_WR, 16'h0000);
      for (int k = 0; k < 6; k++) begin
         m = 8'($urandom);
         ev = 8'($urandom) & 8'h7F;
         cmd(CMD_ESE_WR, {8'h00, m});
         std_event <= ev;
         outbuf_pending <= ev[0];
         @(posedge clock);
         std_event <= '0;
         @(posedge clock);
         q(CMD_STB_RD, {10'h000, |(ev & m & 8'h3C), ev[0], 4'h0});
         q(CMD_ESR_RD, {8'h00, ev & 8'h3C});
         q(CMD_STB_RD, {11'h000, ev[0], 4'h0});
      end
      outbuf_pending <= 1'b0;
      cmd(CMD_ESE_WR, 16'h0000);
      q(CMD_ESE_RD, 16'h0000);
      cmd(CMD_SRE_WR, 16'h0044);
      q(CMD_SRE_RD, 16'h0004);
      cmd(CMD_SRE_WR, 16'h0000);
      q(CMD_SRE_RD, 16'h0000);
      cmd(CMD_PSC_WR, 16'h0000);
      q(CMD_PSC_RD, 16'h0000);
      chk(16'(psc_save), 16'h0000);
      for (int k = 0; k < 4; k++) begin
         pin_in <= k[3:0];
         repeat (6) @(posedge clock);
         q(CMD_QCOND_RD, k[15:0]);
      end
      pin_in <= 4'h0;
      repeat (6) @(posedge clock);
      cmd(CMD_CLS);
      pin_in <= 4'hC;
      repeat (6) @(posedge clock);
      pin_in <= 4'h0;
      repeat (6) @(posedge clock);
      cmd(CMD_QEN_WR, 16'h0200);
      q(CMD_QEN_RD, 16'h0200);
      q(CMD_STB_RD, 16'h0008);
      q(CMD_QEV_RD, 16'h0210);
      q(CMD_QEV_RD, 16'h0000);
      q(CMD_STB_RD, 16'h0000);
      std_event <= 8'h10;
      @(posedge clock);
      std_event <= '0;
      cmd(CMD_CLS);
      q(CMD_ESR_RD, 16'h0000);
      q(CMD_QEN_RD, 16'h0200);
      outbuf_full <= 1'b1;
      repeat (2) @(posedge clock);
      chk(16'(cmd_ready), 16'h0000);
      outbuf_full <= 1'b0;
      @(posedge clock);
      chk(16'(cmd_ready), 16'h0001);
      for (int k = 0; k < DEP; k++) begin
         ec[k] = 16'($urandom);
         err_valid <= 1'b1;
         err_code <= ec[k];
         @(posedge clock);
         chk(16'(err_ready), 16'h0001);
      end
      err_valid <= 1'b0;
      @(posedge clock);
      chk(16'(err_ready), 16'h0000);
      chk(16'(error_active), 16'h0001);
      for (int k = 0; k < DEP; k++) begin
         q(CMD_ERR_RD, ec[k]);
      end
      @(posedge clock);
      chk(16'(error_active), 16'h0000);
      q(CMD_ERR_RD, ERR_NONE);
      tally_and_finish();
   end
endmodule : instrument_status_reporting_tb
`default_nettype wire
